// *** inc/serial_port_pkg.sv ***
// constants of the chained serial configuration port
package serial_port_pkg;
   // frame layout, counted in serial clock rising edges
   localparam int CMD_BITS = 32;
   localparam int DATA_BITS = 16;
   localparam int CNT_W = 6;
   localparam logic [5:0] CMD_LAST = 6'h1F;
   localparam logic [5:0] DATA_LAST = 6'h0F;
   // command word 1 fields, as bit positions in the 32-bit command
   localparam int RW_BIT = 31;
   localparam int BCAST_BIT = 30;
   localparam int AUTOINC_BIT = 28;
   localparam int UNIT_HI = 27;
   localparam int UNIT_LO = 23;
   localparam int UNIT_W = 5;
   localparam int ADDR_W = 23;
   // register indices inside the config_status_space
   localparam logic [22:0] CTRL_INDEX = 23'h000000;
   localparam logic [22:0] STATUS_INDEX = 23'h000001;
   // control register fields
   localparam int LOOP_OFF_BIT = 0;
   localparam int SHARED_OUT_BIT = 1;
   localparam int UNIT_FIELD_LO = 8;
   localparam int UNIT_FIELD_HI = 12;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [15:0] REG_RESET = 16'h0000;
   localparam int REG_COUNT_DEF = 4;
   typedef enum logic [2:0] {
      PH_IDLE = 3'b001,
      PH_CMD = 3'b010,
      PH_DATA = 3'b100
   } phase_e;
endpackage

// *** rtl/chained_serial_host_port.sv ***
// slave side of the chained serial configuration port with its register space
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - the port is a slave only; serial clock, serial input and select all come from the host.
// - a falling select starts a transfer and the following bits are taken as a new command.
// - a rising select ends the transfer for this port.
// - up to 32 ports share one select, told apart by their programmed unit address.
// - the port answers only when the command unit address matches its own, unless broadcast is set on a write.
// - with select low the serial input is sampled on each rising clock: 32 command bits, then 16 data bits.
// - after reset the serial output is an unclocked copy of the input, except in the data word of a read.
// - during a read the register contents leave on the output, changing on falling clock edges.
// - with the loop-through-off bit at 1 the input no longer reaches the output, which stays high except in the data word of a read.
// - a change of the loop-through-off bit takes effect within 4 serial clock cycles of the write.
// - command bit 15 of word 1 selects read (1) or write (0).
// - command bit 14 of word 1 is the broadcast flag; on a write every port stores the data.
// - command bits 11 to 7 of word 1 hold the unit address, which resets to zero in the port.
// - with the shared-output bit at 1 the output is released whenever select is high.
module chained_serial_host_port #(
   parameter int REG_COUNT = serial_port_pkg::REG_COUNT_DEF
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic serial_clk,
   input wire logic chip_select_n,
   input wire logic serial_in_line,
   output logic serial_out_line,
   output logic serial_out_enable,
   input wire logic [15:0] status_word,
   output logic loop_through_off,
   output logic shared_output_tristate,
   output logic [serial_port_pkg::UNIT_W-1:0] unit_address,
   output logic [REG_COUNT*16-1:0] config_space_out
);
   import serial_port_pkg::*;

   initial begin
      if (REG_COUNT < 2 || REG_COUNT > 65536) begin
         $error("REG_COUNT must lie between 2 and 65536");
      end
   end

   // a bad package edit stops the build here instead of silently misframing
   initial begin
      if (CNT_W < $clog2(CMD_BITS + 1)) begin
         $error("bit counter too narrow for the command word");
      end
      if (int'(CMD_LAST) != CMD_BITS - 1) begin
         $error("command end count disagrees with the command width");
      end
      if (int'(DATA_LAST) != DATA_BITS - 1) begin
         $error("data end count disagrees with the data width");
      end
      if (DATA_BITS != $bits(status_word)) begin
         $error("data word must match the register width");
      end
      if (CMD_BITS % DATA_BITS != 0) begin
         $error("command must be a whole number of data words");
      end
   end

   // command field positions, counted from the first bit sent
   initial begin
      if (RW_BIT != CMD_BITS - 1) begin
         $error("direction bit must be the first bit of the command");
      end
      if (BCAST_BIT != RW_BIT - 1) begin
         $error("broadcast bit must follow the direction bit");
      end
      if (AUTOINC_BIT >= BCAST_BIT || AUTOINC_BIT <= UNIT_HI) begin
         $error("auto-increment bit must sit between broadcast and unit fields");
      end
      if (UNIT_HI - UNIT_LO + 1 != UNIT_W) begin
         $error("unit address field width disagrees with UNIT_W");
      end
      if (UNIT_LO != ADDR_W) begin
         $error("register address must fill the bits below the unit field");
      end
      if (ADDR_W < 1) begin
         $error("register address needs at least one bit");
      end
   end

   // control word layout
   initial begin
      if (UNIT_FIELD_HI - UNIT_FIELD_LO + 1 != UNIT_W) begin
         $error("stored unit field width disagrees with UNIT_W");
      end
      if (UNIT_FIELD_HI >= DATA_BITS) begin
         $error("stored unit field lies outside the control word");
      end
      if (LOOP_OFF_BIT == SHARED_OUT_BIT) begin
         $error("loop-through and shared-output bits overlap");
      end
      if (LOOP_OFF_BIT >= UNIT_FIELD_LO || SHARED_OUT_BIT >= UNIT_FIELD_LO) begin
         $error("control bits overlap the stored unit field");
      end
   end

   // register indices against the storage actually built
   initial begin
      if (CTRL_INDEX == STATUS_INDEX) begin
         $error("control and status share one index");
      end
      if (int'(CTRL_INDEX) >= REG_COUNT) begin
         $error("control index lies outside the register space");
      end
      if (int'(STATUS_INDEX) >= REG_COUNT) begin
         $error("status index lies outside the register space");
      end
      if (REG_COUNT > (1 << ADDR_W)) begin
         $error("register space larger than the address reach");
      end
   end

   // reset state must give plain loop-through and unit address zero
   initial begin
      if (CTRL_RESET[UNIT_FIELD_HI:UNIT_FIELD_LO] != '0) begin
         $error("unit address must reset to zero");
      end
      if (CTRL_RESET[LOOP_OFF_BIT] != 1'b0) begin
         $error("loop-through must be on after reset");
      end
      if (CTRL_RESET[SHARED_OUT_BIT] != 1'b0) begin
         $error("output must be driven after reset");
      end
   end

   typedef struct packed {
      logic [2:0] cs_ff;
      logic [2:0] ck_ff;
      logic [1:0] sd_ff;
      phase_e phase;
      logic [CNT_W-1:0] cnt;
      logic [CMD_BITS-1:0] cmd_sr;
      logic [DATA_BITS-1:0] data_sr;
      logic is_read;
      logic bcast;
      logic autoinc;
      logic unit_match;
      logic [ADDR_W-1:0] addr;
      logic [DATA_BITS-1:0] tx;
      logic drive;
      logic out_bit;
      logic [REG_COUNT-1:0][15:0] regs;
   } state_s;

   state_s st_q;
   state_s st_d;

   logic cs_high;
   logic cs_fell;
   logic ck_rise;
   logic ck_fall;
   logic bit_in;
   logic [CMD_BITS-1:0] cmd_full;
   logic [DATA_BITS-1:0] data_full;
   logic [ADDR_W-1:0] next_addr;
   logic write_ok;

   // read value of one index; out-of-range indices read as zero
   function automatic logic [15:0] read_reg(input state_s s, input logic [ADDR_W-1:0] a,
                                            input logic [15:0] stat);
      logic [15:0] v;
      v = 16'h0000;
      if (a == STATUS_INDEX) begin
         v = stat;
      end else if (a < ADDR_W'(REG_COUNT)) begin
         v = s.regs[a];
      end
      return v;
   endfunction

   // first stage of each synchroniser feeds only the second stage
   // all three link inputs belong to the host; the port never drives them
   assign cs_high = st_q.cs_ff[1];
   assign cs_fell = st_q.cs_ff[2] & ~st_q.cs_ff[1];
   assign ck_rise = st_q.ck_ff[1] & ~st_q.ck_ff[2];
   assign ck_fall = st_q.ck_ff[2] & ~st_q.ck_ff[1];
   assign bit_in = st_q.sd_ff[1];

   always_comb begin
      st_d = st_q;
      cmd_full = {st_q.cmd_sr[CMD_BITS-2:0], bit_in};
      data_full = {st_q.data_sr[DATA_BITS-2:0], bit_in};
      next_addr = st_q.addr + ADDR_W'(1);
      write_ok = 1'b0;
      st_d.cs_ff = {st_q.cs_ff[1:0], chip_select_n};
      st_d.ck_ff = {st_q.ck_ff[1:0], serial_clk};
      st_d.sd_ff = {st_q.sd_ff[0], serial_in_line};
      if (cs_high) begin
         // select high: drop any partial word, serial clock ignored
         st_d.phase = PH_IDLE;
         st_d.cnt = '0;
         st_d.drive = 1'b0;
      end else begin
         if (cs_fell) begin
            // falling select opens a new command
            st_d.phase = PH_CMD;
            st_d.cnt = '0;
            st_d.drive = 1'b0;
         end
         if (ck_rise) begin
            case (st_d.phase)
               PH_CMD: begin
                  // command bits sampled on rising serial clock
                  st_d.cmd_sr = cmd_full;
                  st_d.cnt = st_d.cnt + CNT_W'(1);
                  if (st_d.cnt == CMD_LAST + CNT_W'(1)) begin
                     st_d.phase = PH_DATA;
                     st_d.cnt = '0;
                     st_d.is_read = cmd_full[RW_BIT];
                     st_d.bcast = cmd_full[BCAST_BIT];
                     st_d.autoinc = cmd_full[AUTOINC_BIT];
                     st_d.addr = cmd_full[ADDR_W-1:0];
                     // unit address compare against the programmed field
                     st_d.unit_match = cmd_full[UNIT_HI:UNIT_LO] ==
                        st_q.regs[CTRL_INDEX][UNIT_FIELD_HI:UNIT_FIELD_LO];
                     if (cmd_full[RW_BIT] && st_d.unit_match) begin
                        // only the addressed port answers a read
                        st_d.tx = read_reg(st_q, cmd_full[ADDR_W-1:0], status_word);
                        st_d.drive = 1'b1;
                     end
                  end
               end
               PH_DATA: begin
                  // data bits sampled on rising serial clock
                  st_d.data_sr = data_full;
                  st_d.cnt = st_d.cnt + CNT_W'(1);
                  if (st_d.cnt == DATA_LAST + CNT_W'(1)) begin
                     st_d.cnt = '0;
                     // write taken on match or broadcast
                     write_ok = ~st_q.is_read & (st_q.unit_match | st_q.bcast);
                     if (write_ok && st_q.addr != STATUS_INDEX &&
                         st_q.addr < ADDR_W'(REG_COUNT)) begin
                        // control bits act from the next system clock
                        st_d.regs[st_q.addr] = data_full;
                     end
                     if (st_q.autoinc) begin
                        st_d.addr = next_addr;
                        if (st_q.is_read && st_q.unit_match) begin
                           st_d.tx = read_reg(st_q, next_addr, status_word);
                        end
                     end else begin
                        // single access: further bits are ignored until select rises
                        st_d.phase = PH_IDLE;
                        st_d.drive = 1'b0;
                     end
                  end
               end
               default: begin
                  st_d.cnt = st_d.cnt;
               end
            endcase
         end
         if (ck_fall && st_q.drive) begin
            // read data changes on the falling serial clock
            st_d.out_bit = st_q.tx[DATA_BITS-1];
            st_d.tx = {st_q.tx[DATA_BITS-2:0], 1'b0};
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         st_q.cs_ff <= 3'h7;
         st_q.ck_ff <= 3'h0;
         st_q.sd_ff <= 2'h0;
         st_q.phase <= PH_IDLE;
         st_q.cnt <= '0;
         st_q.cmd_sr <= '0;
         st_q.data_sr <= '0;
         st_q.is_read <= 1'b0;
         st_q.bcast <= 1'b0;
         st_q.autoinc <= 1'b0;
         st_q.unit_match <= 1'b0;
         st_q.addr <= '0;
         st_q.tx <= '0;
         st_q.drive <= 1'b0;
         st_q.out_bit <= 1'b0;
         for (int i = 0; i < REG_COUNT; i++) begin
            st_q.regs[i] <= REG_RESET;
         end
         st_q.regs[CTRL_INDEX] <= CTRL_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   assign loop_through_off = st_q.regs[CTRL_INDEX][LOOP_OFF_BIT];
   assign shared_output_tristate = st_q.regs[CTRL_INDEX][SHARED_OUT_BIT];
   assign unit_address = st_q.regs[CTRL_INDEX][UNIT_FIELD_HI:UNIT_FIELD_LO];

   generate
      for (genvar g = 0; g < REG_COUNT; g++) begin : g_out
         assign config_space_out[g*16 +: 16] = st_q.regs[g];
      end
   endgenerate

   // loop-through path is deliberately unclocked so a chain adds only gate delay
   assign serial_out_line = st_q.drive ? st_q.out_bit :
                            (loop_through_off ? 1'b1 : serial_in_line);
   // released while select is high in shared mode
   assign serial_out_enable = ~(shared_output_tristate & cs_high);
endmodule

`default_nettype wire

// *** test/serial_port_chk_asserts.sv ***
// assertions on the serial port pins and control outputs
`timescale 1ns/100ps
`default_nettype none
module serial_port_chk #(parameter int REG_COUNT = 4) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic serial_clk,
   input wire logic chip_select_n,
   input wire logic serial_in_line,
   input wire logic serial_out_line,
   input wire logic serial_out_enable,
   input wire logic [15:0] status_word,
   input wire logic loop_through_off,
   input wire logic shared_output_tristate,
   input wire logic [serial_port_pkg::UNIT_W-1:0] unit_address,
   input wire logic [REG_COUNT*16-1:0] config_space_out
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   // select must have been high past the synchroniser delay
   chk_loop_copy: assert property (chip_select_n && $past(chip_select_n, 4) &&
      !loop_through_off |-> serial_out_line == serial_in_line) else $error("copy lost");
   chk_link_high: assert property (chip_select_n && $past(chip_select_n, 4) &&
      loop_through_off |-> serial_out_line) else $error("output not high");
   chk_share_hiz: assert property (chip_select_n && $past(chip_select_n, 3) &&
      shared_output_tristate |-> !serial_out_enable) else $error("output not released");
   chk_sel_drive: assert property (!chip_select_n && !$past(chip_select_n, 3)
      |-> serial_out_enable) else $error("output not driven");
   chk_share_off: assert property (!shared_output_tristate |-> serial_out_enable)
      else $error("output released");
   chk_reset_zero: assert property ($past(reset) |-> config_space_out == '0 &&
      unit_address == 5'h00) else $error("bad reset value");
   chk_write_frame: assert property ($changed(config_space_out) |->
      !$past(chip_select_n, 4)) else $error("write outside frame");
   chk_out_edge: assert property ($changed(serial_out_line) && $stable(serial_in_line) &&
      $stable(loop_through_off) && !chip_select_n |-> $past(serial_clk) != $past(serial_clk, 6))
      else $error("output moved without clock edge");
   cov_read: cover property (!chip_select_n && serial_out_line != serial_in_line);
   cov_hiz: cover property (!serial_out_enable);
   cov_unit: cover property ($changed(unit_address));
endmodule
bind chained_serial_host_port serial_port_chk #(.REG_COUNT(REG_COUNT)) u_serial_port_chk (
   .sys_clk(sys_clk), .reset(reset), .serial_clk(serial_clk), .chip_select_n(chip_select_n),
   .serial_in_line(serial_in_line), .serial_out_line(serial_out_line),
   .serial_out_enable(serial_out_enable), .status_word(status_word),
   .loop_through_off(loop_through_off), .shared_output_tristate(shared_output_tristate),
   .unit_address(unit_address), .config_space_out(config_space_out));
`default_nettype wire

// *** test/serial_host.sv ***
// host model driving select, serial clock and serial input
`timescale 1ns/100ps
`default_nettype none
module serial_host (
   output logic sclk,
   output logic cs_n,
   output logic serial_in_line,
   input wire logic serial_out_line
);
   initial begin
      sclk = 1'b0; // clock stands still outside frames
      cs_n = 1'b1;
      serial_in_line = 1'b0;
   end
   // n below 48 closes the frame early; idle gap first keeps the config delay
   task automatic xfer(input logic [47:0] w, input int n, output logic [15:0] rd);
      rd = 16'h0000;
      #1280 cs_n = 1'b0;
      for (int i = 47; i >= 48 - n; i--) begin
         serial_in_line = w[i];
         #160 sclk = 1'b1;
         if (i < 16)
            rd[i] = serial_out_line;
         #160 sclk = 1'b0;
      end
      #160 cs_n = 1'b1;
      serial_in_line = ~serial_in_line;
   endtask
endmodule
`default_nettype wire

// *** test/test_chained_serial_host_port.sv ***
// self-checking bench of the chained serial configuration port
`timescale 1ns/100ps
`default_nettype none
module test_chained_serial_host_port;
   import serial_port_pkg::*;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic [15:0] status_word = 16'h0000;
   logic sclk, cs_n, si, so, oe, lo, sh;
   logic [4:0] ua, u;
   logic [63:0] cfg;
   logic [15:0] rd, d;
   int err_total = 0;
   int n_checks = 0;
   always #20 sys_clk = ~sys_clk;
   serial_host u_serial_host (.sclk(sclk), .cs_n(cs_n), .serial_in_line(si),
      .serial_out_line(so));
   chained_serial_host_port u_chained_serial_host_port (.sys_clk(sys_clk), .reset(reset),
      .serial_clk(sclk), .chip_select_n(cs_n), .serial_in_line(si), .serial_out_line(so),
      .serial_out_enable(oe), .status_word(status_word), .loop_through_off(lo),
      .shared_output_tristate(sh), .unit_address(ua), .config_space_out(cfg));
   function automatic logic [15:0] ctrl(input logic [4:0] un, input logic [1:0] m);
      return {3'h0, un, 6'h00, m};
   endfunction
   task automatic go(input logic rw, input logic bc, input logic [4:0] un,
      input logic [22:0] a, input logic [15:0] dw, input int n = 48);
      u_serial_host.xfer({rw, bc, 2'b10, un, a, dw}, n, rd);
   endtask
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      d = 16'($urandom(32'h714E));
      repeat (6) @(negedge sys_clk);
      reset = 1'b0;
      u = 5'($urandom_range(31, 1));
      status_word = 16'($urandom);
      cmp({15'h0, so}, {15'h0, si});
      go(1'b0, 1'b0, 5'h00, CTRL_INDEX, ctrl(u, 2'b01));
      cmp({10'h0, lo, ua}, {10'h0, 1'b1, u});
      go(1'b0, 1'b0, u, CTRL_INDEX, ctrl(u, 2'b00));
      cmp({11'h0, ua}, {11'h0, u});
      go(1'b0, 1'b0, 5'h00, 23'h2, 16'hFFFF);
      cmp(cfg[47:32], 16'h0000);
      // odd passes broadcast to a foreign unit address
      for (int k = 0; k < 4; k++) begin
         d = 16'($urandom);
         go(1'b0, k[0], u ^ {4'h0, k[0]}, 23'h2 + 23'(k[0]), d);
         go(1'b1, 1'b0, u, 23'h2 + 23'(k[0]), ~d);
         cmp(rd, d);
      end
      go(1'b0, 1'b0, u, 23'h3, ~d, 40);
      cmp(cfg[63:48], d);
      go(1'b1, 1'b0, u, STATUS_INDEX, 16'h0000);
      cmp(rd, status_word);
      go(1'b1, 1'b0, u ^ 5'h10, 23'h3, ~d);
      cmp(rd, ~d);
      go(1'b0, 1'b0, u, CTRL_INDEX, ctrl(u, 2'b11));
      repeat (4) @(negedge sys_clk);
      u_serial_host.serial_in_line = 1'b0;
      #1 cmp({13'h0, sh, oe, so}, 16'h0005);
      go(1'b0, 1'b1, 5'h00, CTRL_INDEX, ctrl(u, 2'b00));
      cmp({13'h0, sh, oe, lo}, 16'h0002);
      stop_test();
   end
   initial begin
      #1000000;
      err_total++;
      stop_test();
   end
endmodule
`default_nettype wire
